/* pbc_pkg.sv */
package pbc_pkg;
    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [11:0] OFF_HEADER = 12'h280;
    localparam logic [11:0] OFF_SELECT = 12'h284;
    localparam logic [11:0] OFF_WINDOW = 12'h288;
    localparam logic [11:0] OFF_ALLOC = 12'h28c;
    localparam logic [11:0] OFF_VALUE0 = 12'h300;
    localparam logic [11:0] OFF_CONTROL = 12'h340;
    // ------------------------------------------------------------
    // fields and counts
    // ------------------------------------------------------------
    localparam int ID_LSB = 0;
    localparam int ID_MSB = 15;
    localparam int VER_LSB = 16;
    localparam int VER_MSB = 19;
    localparam int NXT_LSB = 20;
    localparam int NXT_MSB = 31;
    localparam int SEL_MSB = 7;
    localparam int ALLOC_BIT = 0;
    localparam int UNLOCK_BIT = 0;
    localparam int LOADER_BIT = 1;
    localparam int NUM_VALUES = 10;
    localparam logic [7:0] MAX_SEL = 8'h09;
    localparam logic [31:0] HEADER_RESET = 32'h0000_0000;
    localparam logic [7:0] SELECT_RESET = 8'h00;
    localparam logic [31:0] WINDOW_RESET = 32'h0000_0000;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
endpackage

/* pbc_value_entry.sv */
`timescale 1ns/1ns
`default_nettype none
module pbc_value_entry (
    // clock and fundamental reset
    input wire logic hclk,
    input wire logic fund_rstn,
    // write port
    input wire logic wr_en,
    input wire logic [31:0] wr_data,
    // stored value
    output logic [31:0] value
);
    // sticky: cleared only by fundamental reset
    always_ff @(posedge hclk or negedge fund_rstn) begin
        if (!fund_rstn) begin
            value <= 32'h0000_0000;
        end else if (wr_en) begin
            value <= wr_data;
        end
    end
endmodule
`default_nettype wire

/* pbc_window_mux.sv */
`timescale 1ns/1ns
`default_nettype none
module pbc_window_mux (
    // selector and values
    input wire logic [7:0] sel,
    input wire logic [pbc_pkg::NUM_VALUES*32-1:0] values,
    // selected value
    output logic [31:0] data
);
    logic [31:0] picked;
    always_comb begin
        picked = 32'h0000_0000;
        for (int i = 0; i < pbc_pkg::NUM_VALUES; i++) begin
            if (sel == 8'(i)) begin
                picked = values[i*32 +: 32];
            end
        end
    end
    assign data = (sel > pbc_pkg::MAX_SEL) ? 32'h0000_0000 : picked;
endmodule
`default_nettype wire

/* pbc_regs.sv */
// Function
// - header bits 15:0 hold the capability identifier, reset zero, 0x4 means power budget.
// - header bits 19:16 hold the capability version, reset zero, 0x1 means version one.
// - select register bits 7:0 are a read-write selector, reset zero.
// - selector above nine makes the data window read zero.
// - data window returns the selected value register, else zero; reset zero.
// - alloc register bit 0 is the sticky system-allocated flag, reset zero.
// - ten sticky 32-bit budget value registers.
// - value registers are writable only while the unlock bit is set.
// - with unlock clear, writes to value registers are dropped.
// - sticky fields survive hot reset; only fundamental reset clears them.
//
// Implementation choice: register access over AHB-Lite.
`timescale 1ns/1ns
`default_nettype none
module pbc_regs (
    // clock and resets
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hot_rstn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp
);
    // ------------------------------------------------------------
    // address phase capture
    // ------------------------------------------------------------
    logic wr_pend;
    logic [11:0] wr_addr;
    // fundamental reset also clears everything that hot reset clears
    wire soft_rstn = hresetn && hot_rstn;
    wire addr_ok = hsel && hready && htrans == pbc_pkg::HTRANS_NONSEQ && hsize == pbc_pkg::HSIZE_WORD;
    wire rd_req = addr_ok && !hwrite;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_addr <= 12'h000;
        end else begin
            wr_pend <= addr_ok && hwrite;
            wr_addr <= haddr;
        end
    end
    // ------------------------------------------------------------
    // control register: unlock and loader mode
    // ------------------------------------------------------------
    logic [1:0] control;
    wire ctl_wr = wr_pend && wr_addr == pbc_pkg::OFF_CONTROL;
    always_ff @(posedge hclk or negedge soft_rstn) begin
        if (!soft_rstn) begin
            control <= 2'h0;
        end else if (ctl_wr) begin
            control <= hwdata[1:0];
        end
    end
    wire unlocked = control[pbc_pkg::UNLOCK_BIT];
    wire loader = control[pbc_pkg::LOADER_BIT];
    // ------------------------------------------------------------
    // header, selector and system-allocated flag
    // ------------------------------------------------------------
    logic [31:0] header;
    logic [7:0] selector;
    logic alloc_flag;
    wire hdr_wr = wr_pend && loader && wr_addr == pbc_pkg::OFF_HEADER;
    wire sel_wr = wr_pend && wr_addr == pbc_pkg::OFF_SELECT;
    wire alc_wr = wr_pend && loader && wr_addr == pbc_pkg::OFF_ALLOC;
    always_ff @(posedge hclk or negedge soft_rstn) begin
        if (!soft_rstn) begin
            header <= pbc_pkg::HEADER_RESET;
            selector <= pbc_pkg::SELECT_RESET;
        end else begin
            if (hdr_wr) begin
                header <= hwdata;
            end
            if (sel_wr) begin
                selector <= hwdata[pbc_pkg::SEL_MSB:0];
            end
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            alloc_flag <= 1'b0;
        end else if (alc_wr) begin
            alloc_flag <= hwdata[pbc_pkg::ALLOC_BIT];
        end
    end
    // ------------------------------------------------------------
    // value array
    // ------------------------------------------------------------
    logic [pbc_pkg::NUM_VALUES*32-1:0] values;
    logic [pbc_pkg::NUM_VALUES-1:0] val_wr;
    logic [pbc_pkg::NUM_VALUES-1:0] val_hit;
    genvar g;
    generate
        for (g = 0; g < pbc_pkg::NUM_VALUES; g++) begin : gen_val
            assign val_hit[g] = wr_addr == pbc_pkg::OFF_VALUE0 + 12'(4 * g);
            assign val_wr[g] = wr_pend && unlocked && val_hit[g];
            pbc_value_entry u_entry (
                .hclk(hclk),
                .fund_rstn(hresetn),
                .wr_en(val_wr[g]),
                .wr_data(hwdata),
                .value(values[g*32 +: 32])
            );
        end
    endgenerate
    // ------------------------------------------------------------
    // data window and read mux
    // ------------------------------------------------------------
    logic [31:0] window;
    pbc_window_mux u_mux (
        .sel(selector),
        .values(values),
        .data(window)
    );
    logic [31:0] rd_val;
    always_comb begin
        rd_val = 32'h0000_0000;
        if (haddr == pbc_pkg::OFF_HEADER) begin
            rd_val = header;
        end else if (haddr == pbc_pkg::OFF_SELECT) begin
            rd_val = {24'h000000, selector};
        end else if (haddr == pbc_pkg::OFF_WINDOW) begin
            rd_val = window;
        end else if (haddr == pbc_pkg::OFF_ALLOC) begin
            rd_val = {31'h00000000, alloc_flag};
        end else if (haddr == pbc_pkg::OFF_CONTROL) begin
            rd_val = {30'h00000000, control};
        end else begin
            for (int i = 0; i < pbc_pkg::NUM_VALUES; i++) begin
                if (haddr == pbc_pkg::OFF_VALUE0 + 12'(4 * i)) begin
                    rd_val = values[i*32 +: 32];
                end
            end
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= pbc_pkg::WINDOW_RESET;
        end else if (rd_req) begin
            hrdata <= rd_val;
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end
    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence locked_write_s;
        wr_pend && !unlocked && val_hit[0];
    endsequence
    locked_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
        locked_write_s |=> $stable(values[31:0]))
        else $error("locked value changed");
    unlock_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (wr_pend && unlocked && val_hit[0]) |=> values[31:0] == $past(hwdata))
        else $error("unlocked write lost");
    window_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (rd_req && haddr == pbc_pkg::OFF_WINDOW && selector > 8'h09) |=> hrdata == 32'h0000_0000)
        else $error("window nonzero for big selector");
    window_pick_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (rd_req && haddr == pbc_pkg::OFF_WINDOW && selector == 8'h03) |=> hrdata == $past(values[127:96]))
        else $error("window wrong entry");
    select_write_a: assert property (@(posedge hclk) disable iff (!hresetn || !hot_rstn)
        (wr_pend && wr_addr == pbc_pkg::OFF_SELECT) |=> selector == $past(hwdata[7:0]))
        else $error("selector not written");
    header_lock_a: assert property (@(posedge hclk) disable iff (!hresetn || !hot_rstn)
        (wr_pend && !loader && wr_addr == pbc_pkg::OFF_HEADER) |=> $stable(header))
        else $error("header written without loader");
    header_load_a: assert property (@(posedge hclk) disable iff (!hresetn || !hot_rstn)
        hdr_wr |=> header[15:0] == $past(hwdata[15:0]) && header[19:16] == $past(hwdata[19:16]))
        else $error("header id or version not loaded");
    alloc_sticky_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (!hot_rstn && !alc_wr) |=> $stable(alloc_flag))
        else $error("flag lost on hot reset");
    alloc_lock_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (wr_pend && !loader && wr_addr == pbc_pkg::OFF_ALLOC) |=> $stable(alloc_flag))
        else $error("flag written without loader");
    version_reset_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !hot_rstn |-> header[19:16] == 4'h0)
        else $error("version not reset");
    alloc_load_a: assert property (@(posedge hclk) disable iff (!hresetn)
        alc_wr |=> alloc_flag == $past(hwdata[0]))
        else $error("flag not loaded");
    value_sticky_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !hot_rstn |=> $stable(values[319:288]))
        else $error("value lost on hot reset");
    control_reset_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !hot_rstn |-> !unlocked && !loader)
        else $error("control not cleared by hot reset");
endmodule
`default_nettype wire

/* power_budget_capability_regs_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module power_budget_capability_regs_tb;
    logic hclk, hresetn, hot_rstn, hsel, hwrite, hreadyout, hresp;
    logic [11:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, q;
    int err_count, checks_done;

    pbc_regs dut (
        .hclk(hclk), .hresetn(hresetn), .hot_rstn(hot_rstn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp)
    );

    initial begin
        hclk = 0;
        forever #5 hclk = ~hclk;
    end

    // ------------------------------------------------------------
    // bus tasks
    // ------------------------------------------------------------
    task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= pbc_pkg::HTRANS_NONSEQ;
        hwrite <= w;
        hsize <= pbc_pkg::HSIZE_WORD;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        xfer(a, 1'b1, d, r);
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic rc(input logic [11:0] a, input logic [31:0] e, input string n);
        logic [31:0] r;
        xfer(a, 1'b0, 32'h0, r);
        chk(n, e, r);
    endtask

    function automatic logic [31:0] val(input int i);
        return 32'ha5c3_0000 + 32'(i * 32'h0111);
    endfunction

    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        {hresetn, hot_rstn, hsel, hwrite} = 4'h0;
        {haddr, htrans, hsize, hwdata} = '0;
        repeat (5) @(posedge hclk);
        hot_rstn <= 1'b1;
        hresetn <= 1'b1;
        @(posedge hclk);
        rc(pbc_pkg::OFF_HEADER, 32'h0, "header reset");
        rc(pbc_pkg::OFF_SELECT, 32'h0, "select reset");
        rc(pbc_pkg::OFF_WINDOW, 32'h0, "window reset");
        rc(pbc_pkg::OFF_ALLOC, 32'h0, "alloc reset");
        rc(12'h2f0, 32'h0, "unmapped");
        $display("test reset values done");
        wr(pbc_pkg::OFF_HEADER, 32'h0001_0004);
        rc(pbc_pkg::OFF_HEADER, 32'h0, "header locked");
        wr(pbc_pkg::OFF_ALLOC, 32'h1);
        rc(pbc_pkg::OFF_ALLOC, 32'h0, "alloc locked");
        wr(pbc_pkg::OFF_CONTROL, 32'h2);
        wr(pbc_pkg::OFF_HEADER, 32'h0001_0004);
        rc(pbc_pkg::OFF_HEADER, 32'h0001_0004, "header loaded");
        wr(pbc_pkg::OFF_ALLOC, 32'hffff_ffff);
        rc(pbc_pkg::OFF_ALLOC, 32'h1, "alloc loaded");
        wr(pbc_pkg::OFF_VALUE0, 32'h1234_5678);
        rc(pbc_pkg::OFF_VALUE0, 32'h0, "value locked");
        $display("test lock done");
        wr(pbc_pkg::OFF_CONTROL, 32'h3);
        for (int i = 0; i < 10; i++) wr(pbc_pkg::OFF_VALUE0 + 12'(4 * i), val(i));
        for (int i = 0; i < 10; i++) rc(pbc_pkg::OFF_VALUE0 + 12'(4 * i), val(i), "value");
        for (int i = 0; i < 12; i++) begin
            wr(pbc_pkg::OFF_SELECT, 32'(i));
            rc(pbc_pkg::OFF_WINDOW, (i < 10) ? val(i) : 32'h0, "window");
        end
        wr(pbc_pkg::OFF_SELECT, 32'hffff_ff07);
        rc(pbc_pkg::OFF_SELECT, 32'h07, "select width");
        rc(pbc_pkg::OFF_WINDOW, val(7), "window sel7");
        wr(pbc_pkg::OFF_WINDOW, 32'h0);
        rc(pbc_pkg::OFF_WINDOW, val(7), "window ro");
        $display("test values done");
        hot_rstn <= 1'b0;
        repeat (2) @(posedge hclk);
        hot_rstn <= 1'b1;
        @(posedge hclk);
        rc(pbc_pkg::OFF_VALUE0 + 12'h24, val(9), "value hot");
        rc(pbc_pkg::OFF_ALLOC, 32'h1, "alloc hot");
        rc(pbc_pkg::OFF_SELECT, 32'h0, "select hot");
        wr(pbc_pkg::OFF_VALUE0 + 12'h24, 32'h0);
        rc(pbc_pkg::OFF_VALUE0 + 12'h24, val(9), "value relock");
        $display("test hot reset done");
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rc(pbc_pkg::OFF_VALUE0 + 12'h24, 32'h0, "value fund");
        rc(pbc_pkg::OFF_ALLOC, 32'h0, "alloc fund");
        $display("test fundamental reset done");
        end_sim();
    end

    initial begin
        repeat (3000) @(posedge hclk);
        err_count++;
        end_sim();
    end
endmodule
`default_nettype wire
